//--- verilog/ttl_io_cfg.svh
// constants for the ttl i/o control block: reset values, pin levels, mode codes
// assumes inclusion by bare name from each design file
`ifndef TTL_IO_CFG_SVH
`define TTL_IO_CFG_SVH

// pin levels and the level an idle (pulled-up) input rests at
`define PIN_IDLE 1'b1
`define LEVEL_LOW 1'b0
`define LEVEL_HIGH 1'b1

// direction output encoding and its reset value
`define DIR_INFUSE 1'b1
`define DIR_WITHDRAW 1'b0
`define DIR_RESET `DIR_INFUSE

// program output reset level
`define PROG_OUT_RESET 1'b0

// motor-running output modes
`define RUN_MODE_PUMP_ONLY 1'b0
`define RUN_MODE_WITH_PAUSE 1'b1

// synchroniser fill counter: edges are reported only once both stages and the
// remembered level hold pin data, so a pin already low at reset makes no edge
`define SYNC_FILL_RESET 2'h0
`define SYNC_FILL_STEP 2'h1
`define SYNC_FILL_DONE 2'h3

// least spacing of level changes the far side keeps on trigger and direction pins
`define INPUT_MIN_GAP_MS 50
`define CLK_SYS_KHZ 100000
`define INPUT_MIN_GAP_CYC (`INPUT_MIN_GAP_MS * `CLK_SYS_KHZ)

`endif

//--- verilog/ttl_io_pkg.sv
// types shared by the ttl i/o control block
// assumes nothing beyond a systemverilog compiler
package ttl_io_pkg;

   // operational trigger modes, selected by trigger_mode_setting
   typedef enum logic [3:0] {
      TRIG_OFF,
      TRIG_FOOT,
      TRIG_FOOT_HOLD,
      TRIG_FOOT_REV,
      TRIG_LEVEL_EDGE,
      TRIG_START_ONLY,
      TRIG_START_ONLY_REV,
      TRIG_STOP_ONLY,
      TRIG_STOP_ONLY_REV,
      TRIG_RUN_LOW,
      TRIG_RUN_HIGH,
      TRIG_STOP_LOW,
      TRIG_STOP_HIGH,
      TRIG_EVENT_TRAP,
      TRIG_BUTTON_EVENT
   } trig_mode_e;

   // direction input modes: reciprocating_setting is 0, dual_setting is 1
   typedef enum logic {
      RECIPROCATING_SETTING,
      DUAL_SETTING
   } dir_mode_e;

   // synchroniser state
   typedef struct packed {
      logic s1;
      logic s2;
      logic prev;
      logic [1:0] fill;
   } sync_s;

   // top-level control state
   typedef struct packed {
      logic dir;
      logic prog_out;
      logic motor_run;
      logic start_req;
      logic stop_req;
      logic event_trap_req;
      logic resume_req;
      logic level_wait;
      logic run_seen;
      logic [3:0] in_levels;
      logic in_levels_valid;
   } ctrl_s;

endpackage

//--- verilog/pin_sync_edge.sv
// two-stage synchroniser with edge detection for one asynchronous input pin
// assumes the pin is unrelated to clk_sys; reports each edge once as a pulse
`timescale 1ns/1ps
`include "ttl_io_cfg.svh"

module pin_sync_edge
   import ttl_io_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic pin_async,
   output logic level,
   output logic rise,
   output logic fall
);

   sync_s st_r;
   sync_s st_nxt;

   // shift pin through two stages, remember last synchronised level
   always_comb begin
      st_nxt = st_r;
      st_nxt.s1 = pin_async;
      st_nxt.s2 = st_r.s1;
      st_nxt.prev = st_r.s2;
      if (st_r.fill != `SYNC_FILL_DONE) begin
         st_nxt.fill = st_r.fill + `SYNC_FILL_STEP;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         st_r <= '{s1: `PIN_IDLE, s2: `PIN_IDLE, prev: `PIN_IDLE, fill: `SYNC_FILL_RESET};
      end else begin
         st_r <= st_nxt;
      end
   end

   // edges only once both stages and the remembered level carry real pin data
   assign level = st_r.s2;
   assign rise = (st_r.fill == `SYNC_FILL_DONE) & st_r.s2 & ~st_r.prev;
   assign fall = (st_r.fill == `SYNC_FILL_DONE) & ~st_r.s2 & st_r.prev;

endmodule

//--- verilog/jump_request_unit.sv
// phase jump requests from the event input and the program input
// assumes synchronised edges and levels from pin_sync_edge on the same clock
`timescale 1ns/1ps
`include "ttl_io_cfg.svh"

module jump_request_unit #(
   parameter int PHASE_W = 7
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic event_rise,
   input wire logic event_fall,
   input wire logic prog_in_level,
   input wire logic event_jump_fn,
   input wire logic either_edge_event_jump_fn,
   input wire logic [PHASE_W-1:0] event_phase,
   input wire logic conditional_input_jump_fn,
   input wire logic [PHASE_W-1:0] cond_phase,
   output logic jump_req,
   output logic [PHASE_W-1:0] jump_phase,
   output logic cond_done
);

   typedef struct packed {
      logic req;
      logic [PHASE_W-1:0] phase;
      logic done;
   } jump_s;

   jump_s st_r;
   jump_s st_nxt;

   // conditional test takes precedence over an event jump in the same cycle
   always_comb begin
      st_nxt = st_r;
      st_nxt.req = 1'b0;
      st_nxt.done = conditional_input_jump_fn;
      if (conditional_input_jump_fn) begin
         if (prog_in_level == `LEVEL_LOW) begin
            st_nxt.req = 1'b1;
            st_nxt.phase = cond_phase;
         end
      end else if (either_edge_event_jump_fn && (event_rise || event_fall)) begin
         st_nxt.req = 1'b1;
         st_nxt.phase = event_phase;
      end else if (event_jump_fn && event_fall) begin
         st_nxt.req = 1'b1;
         st_nxt.phase = event_phase;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign jump_req = st_r.req;
   assign jump_phase = st_r.phase;
   assign cond_done = st_r.done;

endmodule

//--- verilog/pump_ttl_io_control.sv
// control logic behind the pump's ttl i/o connector
// assumes one clock clk_sys at 100 MHz, synchronous active-high rst,
// and a program sequencer that answers the one-cycle request pulses
`timescale 1ns/1ps
`include "ttl_io_cfg.svh"

// Function
// - trigger and direction pins ignored while keypad editing is under way
// - trigger and direction pins ignored while an alarm is present
// - foot switch mode: each falling edge toggles the program
// - foot switch hold: falling edge starts, following rising edge stops
// - reversed foot switch: each rising edge toggles the program
// - level control edges: falling edge stops, rising edge starts
// - start only: the edge may only start, and only when a start is allowed
// - stop only: the edge may only stop, never start
// - level modes act on the present level, run or stop while it matches
// - trigger off: the trigger pin has no effect
// - event trap mode redirects trigger stops; button event redirects the stop key
// - motor output shows pumping, plus pause timer when mode is 1
// - direction pin acts like the direction key, only where that is permitted
// - reciprocating: fall while withdrawing gives infuse, rise while infusing gives withdraw
// - dual: rise while withdrawing gives infuse, fall while infusing gives withdraw
// - direction output high for infuse, low for withdraw
// - set-output function drives the program output to its level
// - armed event jump: falling event edge jumps to the target phase
// - armed either-edge event jump: any event edge jumps to the phase
// - conditional input: low program input jumps to the given phase
// - pause until trigger: trigger activation resumes the program
// - host reads the four input levels and sets the program output
module pump_ttl_io_control
   import ttl_io_pkg::*;
#(
   parameter int PHASE_W = 7
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic trig_pin,
   input wire logic dir_pin,
   input wire logic event_pin,
   input wire logic prog_in_pin,
   input wire trig_mode_e trigger_mode_setting,
   input wire dir_mode_e dir_input_mode,
   input wire logic run_output_mode,
   input wire logic keypad_editing,
   input wire logic alarm_active,
   input wire logic prog_running,
   input wire logic start_allowed,
   input wire logic motor_pumping,
   input wire logic pause_timer_active,
   input wire logic pause_until_trigger_fn,
   input wire logic stop_key_press,
   input wire logic dir_key_press,
   input wire logic dir_key_permitted,
   input wire logic set_output_fn,
   input wire logic set_output_level,
   input wire logic event_jump_fn,
   input wire logic either_edge_event_jump_fn,
   input wire logic [PHASE_W-1:0] event_phase,
   input wire logic conditional_input_jump_fn,
   input wire logic [PHASE_W-1:0] cond_phase,
   input wire logic host_in_query,
   input wire logic host_out_wr,
   input wire logic host_out_level,
   output logic start_req,
   output logic stop_req,
   output logic event_trap_req,
   output logic resume_req,
   output logic jump_req,
   output logic [PHASE_W-1:0] jump_phase,
   output logic cond_done,
   output logic motor_run_pin,
   output logic dir_out_pin,
   output logic prog_out_pin,
   output logic [3:0] in_levels,
   output logic in_levels_valid
);

   ctrl_s st_r;
   ctrl_s st_nxt;

   logic trig_level;
   logic trig_rise;
   logic trig_fall;
   logic dir_level;
   logic dir_rise;
   logic dir_fall;
   logic event_level;
   logic event_rise;
   logic event_fall;
   logic prog_in_level;

   // pin synchronisers
   pin_sync_edge u_sync_trig (
      .clk_sys(clk_sys),
      .rst(rst),
      .pin_async(trig_pin),
      .level(trig_level),
      .rise(trig_rise),
      .fall(trig_fall)
   );

   pin_sync_edge u_sync_dir (
      .clk_sys(clk_sys),
      .rst(rst),
      .pin_async(dir_pin),
      .level(dir_level),
      .rise(dir_rise),
      .fall(dir_fall)
   );

   pin_sync_edge u_sync_event (
      .clk_sys(clk_sys),
      .rst(rst),
      .pin_async(event_pin),
      .level(event_level),
      .rise(event_rise),
      .fall(event_fall)
   );

   pin_sync_edge u_sync_prog_in (
      .clk_sys(clk_sys),
      .rst(rst),
      .pin_async(prog_in_pin),
      .level(prog_in_level),
      .rise(),
      .fall()
   );

   // event and conditional phase jumps
   jump_request_unit #(
      .PHASE_W(PHASE_W)
   ) u_jump (
      .clk_sys(clk_sys),
      .rst(rst),
      .event_rise(event_rise),
      .event_fall(event_fall),
      .prog_in_level(prog_in_level),
      .event_jump_fn(event_jump_fn),
      .either_edge_event_jump_fn(either_edge_event_jump_fn),
      .event_phase(event_phase),
      .conditional_input_jump_fn(conditional_input_jump_fn),
      .cond_phase(cond_phase),
      .jump_req(jump_req),
      .jump_phase(jump_phase),
      .cond_done(cond_done)
   );

   logic ignore_ext;
   logic edge_start;
   logic edge_stop;
   logic edge_toggle;
   logic lvl_start;
   logic lvl_stop;
   logic want_start;
   logic want_stop;
   logic lvl_demand;

   // decode the trigger pin into start, stop and toggle demands
   always_comb begin
      ignore_ext = keypad_editing | alarm_active;
      edge_start = 1'b0;
      edge_stop = 1'b0;
      edge_toggle = 1'b0;
      lvl_start = 1'b0;
      lvl_stop = 1'b0;
      unique case (trigger_mode_setting)
         TRIG_OFF: begin
            edge_toggle = 1'b0;
         end
         TRIG_FOOT, TRIG_EVENT_TRAP, TRIG_BUTTON_EVENT: begin
            edge_toggle = trig_fall;
         end
         TRIG_FOOT_HOLD: begin
            edge_start = trig_fall;
            edge_stop = trig_rise;
         end
         TRIG_FOOT_REV: begin
            edge_toggle = trig_rise;
         end
         TRIG_LEVEL_EDGE: begin
            edge_start = trig_rise;
            edge_stop = trig_fall;
         end
         TRIG_START_ONLY: begin
            edge_start = trig_fall & start_allowed;
         end
         TRIG_START_ONLY_REV: begin
            edge_start = trig_rise & start_allowed;
         end
         TRIG_STOP_ONLY: begin
            edge_stop = trig_fall;
         end
         TRIG_STOP_ONLY_REV: begin
            edge_stop = trig_rise;
         end
         TRIG_RUN_LOW: begin
            lvl_start = (trig_level == `LEVEL_LOW);
            lvl_stop = (trig_level == `LEVEL_HIGH);
         end
         TRIG_RUN_HIGH: begin
            lvl_start = (trig_level == `LEVEL_HIGH);
            lvl_stop = (trig_level == `LEVEL_LOW);
         end
         TRIG_STOP_LOW: begin
            lvl_stop = (trig_level == `LEVEL_LOW);
         end
         TRIG_STOP_HIGH: begin
            lvl_stop = (trig_level == `LEVEL_HIGH);
         end
         default: begin
            edge_toggle = 1'b0; // undefined setting codes act as off
         end
      endcase
      // a level demand only counts when it differs from the program state
      lvl_start = lvl_start & ~prog_running;
      lvl_stop = lvl_stop & prog_running;
      lvl_demand = lvl_start | lvl_stop;
      want_start = ~ignore_ext & (edge_start | (edge_toggle & ~prog_running)
                   | (lvl_start & ~st_r.level_wait));
      want_stop = ~ignore_ext & (edge_stop | (edge_toggle & prog_running)
                  | (lvl_stop & ~st_r.level_wait));
   end

   // next control state
   always_comb begin
      st_nxt = st_r;
      st_nxt.start_req = 1'b0;
      st_nxt.stop_req = 1'b0;
      st_nxt.event_trap_req = 1'b0;
      st_nxt.resume_req = 1'b0;
      st_nxt.in_levels_valid = 1'b0;
      st_nxt.run_seen = prog_running;

      // trigger activation: resume a paused program, else start or stop
      if (pause_until_trigger_fn && ~ignore_ext && (edge_start || edge_toggle || lvl_start)) begin
         st_nxt.resume_req = 1'b1;
      end else if (want_start) begin
         st_nxt.start_req = 1'b1;
      end else if (want_stop) begin
         if (trigger_mode_setting == TRIG_EVENT_TRAP) begin
            st_nxt.event_trap_req = 1'b1;
         end else begin
            st_nxt.stop_req = 1'b1;
         end
      end

      // front-panel stop key, redirected in button event mode
      if (stop_key_press) begin
         if (trigger_mode_setting == TRIG_BUTTON_EVENT) begin
            st_nxt.event_trap_req = 1'b1;
         end else begin
            st_nxt.stop_req = 1'b1;
         end
      end

      // one level request per program state change
      if (!lvl_demand || (st_r.run_seen != prog_running)) begin
         st_nxt.level_wait = 1'b0;
      end else if (want_start || want_stop) begin
         st_nxt.level_wait = 1'b1;
      end

      // direction key, then the direction pin where the key is permitted
      if (dir_key_press && dir_key_permitted) begin
         st_nxt.dir = ~st_r.dir;
      end
      if (dir_key_permitted && !ignore_ext) begin
         if (dir_input_mode == RECIPROCATING_SETTING) begin
            if (st_r.dir == `DIR_WITHDRAW && dir_fall) begin
               st_nxt.dir = `DIR_INFUSE;
            end else if (st_r.dir == `DIR_INFUSE && dir_rise) begin
               st_nxt.dir = `DIR_WITHDRAW;
            end
         end else begin
            if (st_r.dir == `DIR_WITHDRAW && dir_rise) begin
               st_nxt.dir = `DIR_INFUSE;
            end else if (st_r.dir == `DIR_INFUSE && dir_fall) begin
               st_nxt.dir = `DIR_WITHDRAW;
            end
         end
      end

      // program output: host write wins over the program in the same cycle
      if (host_out_wr) begin
         st_nxt.prog_out = host_out_level;
      end else if (set_output_fn) begin
         st_nxt.prog_out = set_output_level;
      end

      // motor-running output
      if (run_output_mode == `RUN_MODE_WITH_PAUSE) begin
         st_nxt.motor_run = motor_pumping | pause_timer_active;
      end else begin
         st_nxt.motor_run = motor_pumping;
      end

      // host query snapshot of the input pins
      if (host_in_query) begin
         st_nxt.in_levels = {prog_in_level, event_level, dir_level, trig_level};
         st_nxt.in_levels_valid = 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         st_r <= '0;
         st_r.dir <= `DIR_RESET;
         st_r.prog_out <= `PROG_OUT_RESET;
      end else begin
         st_r <= st_nxt;
      end
   end

   // outputs straight from state
   assign start_req = st_r.start_req;
   assign stop_req = st_r.stop_req;
   assign event_trap_req = st_r.event_trap_req;
   assign resume_req = st_r.resume_req;
   assign motor_run_pin = st_r.motor_run;
   assign dir_out_pin = st_r.dir;
   assign prog_out_pin = st_r.prog_out;
   assign in_levels = st_r.in_levels;
   assign in_levels_valid = st_r.in_levels_valid;

endmodule

//--- tb/ttl_far_side.sv
// far-side model: foot switch or automation logic driving the four input pins
// assumes clk_sys from the bench; every pin rests high through its pull-up
`timescale 1ns/1ps
module ttl_far_side #(
   parameter int GAP = 10
) (
   input wire logic clk_sys,
   output logic [3:0] pins
);
   int gap_cnt = 0;
   initial pins = 4'hf;
   // cycles since the last trigger or direction change
   always @(posedge clk_sys) gap_cnt <= gap_cnt + 1;
   // change one pin just after an edge; gap shortened from the real spacing
   task automatic put(input int i, input logic v);
      while (i < 2 && gap_cnt < GAP) @(posedge clk_sys);
      @(posedge clk_sys);
      #1 pins[i] = v;
      if (i < 2) gap_cnt = 0;
   endtask
endmodule

//--- tb/pump_ttl_io_control_properties.sv
// port assertions for the ttl i/o control block
// assumes clk_sys with synchronous active-high rst; bound at the foot
`timescale 1ns/1ps
module pump_ttl_io_control_properties
   import ttl_io_pkg::*;
#(
   parameter int PHASE_W = 7
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic prog_in_pin,
   input wire trig_mode_e trigger_mode_setting,
   input wire logic run_output_mode,
   input wire logic keypad_editing,
   input wire logic alarm_active,
   input wire logic motor_pumping,
   input wire logic pause_timer_active,
   input wire logic dir_key_permitted,
   input wire logic set_output_fn,
   input wire logic set_output_level,
   input wire logic conditional_input_jump_fn,
   input wire logic [PHASE_W-1:0] cond_phase,
   input wire logic host_in_query,
   input wire logic host_out_wr,
   input wire logic host_out_level,
   input wire logic start_req,
   input wire logic resume_req,
   input wire logic event_trap_req,
   input wire logic jump_req,
   input wire logic [PHASE_W-1:0] jump_phase,
   input wire logic cond_done,
   input wire logic motor_run_pin,
   input wire logic dir_out_pin,
   input wire logic prog_out_pin,
   input wire logic in_levels_valid
);
   logic [2:0] pq;
   wire logic gated = keypad_editing || alarm_active;
   // program input copy, three stages deep
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         pq <= 3'h7;
      end else begin
         pq <= {pq[1:0], prog_in_pin};
      end
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   gate_blocks_start_a: assert property (gated [*2] |=> !start_req && !resume_req)
      else $error("start while gated");
   trig_off_quiet_a: assert property ((trigger_mode_setting == TRIG_OFF) [*2] |=> !start_req && !resume_req)
      else $error("start with trigger off");
   motor_out_a: assert property (!$past(rst) |-> motor_run_pin == $past(motor_pumping ||
      (run_output_mode && pause_timer_active))) else $error("motor output wrong");
   host_out_a: assert property (host_out_wr |=> prog_out_pin == $past(host_out_level))
      else $error("host output level wrong");
   set_out_a: assert property (set_output_fn && !host_out_wr |=> prog_out_pin == $past(set_output_level))
      else $error("program output level wrong");
   out_hold_a: assert property (!set_output_fn && !host_out_wr |=> $stable(prog_out_pin))
      else $error("program output moved");
   query_valid_a: assert property (1 |=> in_levels_valid == $past(host_in_query))
      else $error("query valid wrong");
   cond_jump_a: assert property (conditional_input_jump_fn && pq == 3'h0 |=>
      jump_req && cond_done && jump_phase == $past(cond_phase)) else $error("conditional jump missed");
   cond_pass_a: assert property (conditional_input_jump_fn && pq == 3'h7 |=> cond_done && !jump_req)
      else $error("conditional jump wrong");
   dir_lock_a: assert property ((!dir_key_permitted) [*2] |=> $stable(dir_out_pin))
      else $error("direction moved while locked");
   start_once_a: assert property (start_req |=> !start_req)
      else $error("start repeated");
   cover property (start_req);
   cover property (jump_req);
   cover property (event_trap_req);
endmodule
bind pump_ttl_io_control pump_ttl_io_control_properties #(.PHASE_W(PHASE_W)) chk (.*);

//--- tb/pump_ttl_io_control_test.sv
// self-checking bench for pump_ttl_io_control with a far-side pin model
// assumes design, far-side model and checker are compiled first
`timescale 1ns/1ps
module pump_ttl_io_control_test;
   import ttl_io_pkg::*;
   logic clk_sys = 1'h0;
   logic rst = 1'h1;
   logic [3:0] pins;
   wire logic trig_pin = pins[0];
   wire logic dir_pin = pins[1];
   wire logic event_pin = pins[2];
   wire logic prog_in_pin = pins[3];
   trig_mode_e trigger_mode_setting = TRIG_OFF;
   dir_mode_e dir_input_mode = RECIPROCATING_SETTING;
   logic run_output_mode = 1'h0, keypad_editing = 1'h0, alarm_active = 1'h0, prog_running = 1'h0;
   wire logic start_allowed = !prog_running;
   logic motor_pumping = 1'h0, pause_timer_active = 1'h0, pause_until_trigger_fn = 1'h0;
   logic stop_key_press = 1'h0, dir_key_press = 1'h0, dir_key_permitted = 1'h1;
   logic set_output_fn = 1'h0, set_output_level = 1'h0, event_jump_fn = 1'h0;
   logic either_edge_event_jump_fn = 1'h0, conditional_input_jump_fn = 1'h0;
   logic [6:0] event_phase = 7'h00, cond_phase = 7'h00, jump_phase;
   logic host_in_query = 1'h0, host_out_wr = 1'h0, host_out_level = 1'h0, v;
   logic start_req, stop_req, event_trap_req, resume_req, jump_req, cond_done;
   logic motor_run_pin, dir_out_pin, prog_out_pin, in_levels_valid;
   logic [3:0] in_levels;
   logic [7:0] rq;
   logic jp;
   int miscompares = 0, n_compared = 0, d_exp = 1;
   pump_ttl_io_control #(.PHASE_W(7)) DUT (.*);
   ttl_far_side #(.GAP(10)) far (.clk_sys(clk_sys), .pins(pins));
   always #5 clk_sys = ~clk_sys;
   // sequencer stand-in: follows start and stop requests
   always @(posedge clk_sys) if (start_req || stop_req) prog_running <= start_req;
   initial begin
      repeat (60000) @(posedge clk_sys);
      miscompares++;
      give_verdict();
   end
   task automatic give_verdict();
      $display("compared %0d miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   // first request seen in eight cycles: 1 start 2 stop 3 trap 4 resume
   task automatic watch();
      rq = 8'h00;
      jp = 1'h0;
      repeat (8) begin
         if (rq === 8'h00) rq = resume_req ? 4 : event_trap_req ? 3 : stop_req ? 2 : start_req ? 1 : 0;
         if (jump_req === 1'h1) jp = 1'h1;
         tick(1);
      end
   endtask
   task automatic step(input int i, input logic lv, input logic [7:0] exp);
      far.put(i, lv);
      watch();
      chk(rq, exp);
   endtask
   // direction model: d_exp tracks infuse 1 / withdraw 0
   task automatic dstep(input logic lv, input logic ok);
      if (ok && dir_key_permitted && ((dir_input_mode == RECIPROCATING_SETTING) ? lv == d_exp : lv != d_exp))
         d_exp = !d_exp;
      far.put(1, lv);
      watch();
      chk(dir_out_pin, 8'(d_exp));
   endtask
   function automatic logic [7:0] exp_trig(int m, logic lv, logic r);
      case (m)
         1, 14: return !lv ? (r ? 2 : 1) : 0;
         13: return !lv ? (r ? 3 : 1) : 0;
         2: return lv ? 2 : 1;
         3: return lv ? (r ? 2 : 1) : 0;
         4: return lv ? 1 : 2;
         5: return (!lv && !r) ? 1 : 0;
         6: return (lv && !r) ? 1 : 0;
         7: return !lv ? 2 : 0;
         8: return lv ? 2 : 0;
         9: return !lv ? (r ? 0 : 1) : (r ? 2 : 0);
         10: return lv ? (r ? 0 : 1) : (r ? 2 : 0);
         11: return (!lv && r) ? 2 : 0;
         12: return (lv && r) ? 2 : 0;
         default: return 0;
      endcase
   endfunction
   initial begin
      void'($urandom(86));
      tick(12);
      rst = 1'h0;
      // every trigger mode from a start level and run state that keeps it clear
      for (int m = 0; m < 15; m++) begin
         trigger_mode_setting = TRIG_OFF;
         far.put(0, (m == 10 || m == 12) ? 1'h0 : 1'h1);
         prog_running = (m == 4 || m == 7 || m == 8 || m == 11 || m == 12);
         tick(6);
         trigger_mode_setting = trig_mode_e'(m);
         tick(10);
         for (int k = 0; k < ((m inside {7, 8, 11, 12}) ? 2 : 4); k++) begin
            v = ~pins[0];
            step(0, v, exp_trig(m, v, prog_running));
         end
      end
      prog_running = 1'h1;
      for (int k = 0; k < 2; k++) begin
         if (k == 1) trigger_mode_setting = TRIG_FOOT;
         stop_key_press = 1'h1;
         tick(1);
         stop_key_press = 1'h0;
         watch();
         chk(rq, k ? 8'h02 : 8'h03);
      end
      pause_until_trigger_fn = 1'h1;
      step(0, 1'h0, 8'h04);
      step(0, 1'h1, 8'h00);
      pause_until_trigger_fn = 1'h0;
      for (int g = 0; g < 2; g++) begin
         {alarm_active, keypad_editing} = g ? 2'h2 : 2'h1;
         step(0, 1'h0, 8'h00);
         step(0, 1'h1, 8'h00);
         dstep(~pins[1], 1'h0);
         {alarm_active, keypad_editing} = 2'h0;
      end
      $display("trigger tests done");
      for (int md = 0; md < 2; md++) begin
         dir_input_mode = dir_mode_e'(md);
         if (pins[1] !== 1'h1) dstep(1'h1, 1'h1);
         repeat (2) begin
            dstep(1'h0, 1'h1);
            dstep(1'h1, 1'h1);
         end
      end
      dir_key_permitted = 1'h0;
      dstep(1'h0, 1'h1);
      dstep(1'h1, 1'h1);
      dir_key_permitted = 1'h1;
      dir_key_press = 1'h1;
      tick(1);
      dir_key_press = 1'h0;
      d_exp = !d_exp;
      tick(2);
      chk(dir_out_pin, 8'(d_exp));
      $display("direction tests done");
      for (int e = 0; e < 2; e++) begin
         {either_edge_event_jump_fn, event_jump_fn} = e ? 2'h2 : 2'h1;
         event_phase = 7'($urandom);
         repeat (2) begin
            v = ~pins[2];
            step(2, v, 8'h00);
            chk(jp, 8'(e || !v));
            if (jp === 1'h1) chk(jump_phase, event_phase);
         end
      end
      {either_edge_event_jump_fn, event_jump_fn} = 2'h0;
      for (int c = 0; c < 2; c++) begin
         far.put(3, c[0]);
         tick(6);
         cond_phase = 7'($urandom);
         conditional_input_jump_fn = 1'h1;
         tick(1);
         conditional_input_jump_fn = 1'h0;
         chk({jump_req, cond_done}, c ? 8'h01 : 8'h03);
         if (c == 0) chk(jump_phase, cond_phase);
      end
      $display("jump tests done");
      trigger_mode_setting = TRIG_OFF;
      dir_key_permitted = 1'h0;
      for (int r = 0; r < 2; r++) begin
         v = 1'($urandom);
         for (int i = 0; i < 4; i++) far.put(i, i[0] ^ v ^ r[0]);
         tick(6);
         host_in_query = 1'h1;
         tick(1);
         host_in_query = 1'h0;
         chk({in_levels_valid, in_levels}, {4'h1, pins});
      end
      for (int k = 0; k < 3; k++) begin
         host_out_level = 1'($urandom);
         set_output_level = !host_out_level;
         host_out_wr = (k != 1);
         set_output_fn = (k != 0);
         tick(1);
         {host_out_wr, set_output_fn} = 2'h0;
         chk(prog_out_pin, (k == 1) ? set_output_level : host_out_level);
      end
      for (int i = 0; i < 8; i++) begin
         {run_output_mode, motor_pumping, pause_timer_active} = 3'(i);
         tick(2);
         chk(motor_run_pin, motor_pumping | (run_output_mode & pause_timer_active));
      end
      $display("host and output tests done");
      give_verdict();
   end
endmodule
